/* shared/ibda_defines.vh */
// address map, master codes and target select codes for the internal bus decode/arbiter
`ifndef IBDA_DEFINES_VH
`define IBDA_DEFINES_VH
`define IBDA_EXT_LAST 32'hFF7FFFFF
`define IBDA_WIN_FRONTEND 12'hFF8
`define IBDA_WIN_DMA 12'hFF9
`define IBDA_WIN_HOSTIF 12'hFFA
`define IBDA_WIN_SYSSVC 12'hFFB
`define IBDA_WIN_MEMCTL 12'hFFC
`define IBDA_WIN_SERIAL 12'hFFD
`define IBDA_WIN_HOLE 12'hFFE
`define IBDA_WIN_CACHE 12'hFFF
`define IBDA_INT_TOP8 8'hFF
`define IBDA_EXT_TOP4 4'hF
`define IBDA_M_CPU 2'h0
`define IBDA_M_DMA 2'h1
`define IBDA_M_HOSTIF 2'h2
`define IBDA_M_EXTBUS 2'h3
`define IBDA_SEL_NONE 4'h0
`define IBDA_SEL_EXTBUS 4'h1
`define IBDA_SEL_FRONTEND 4'h2
`define IBDA_SEL_DMA 4'h3
`define IBDA_SEL_HOSTIF 4'h4
`define IBDA_SEL_SYSSVC 4'h5
`define IBDA_SEL_MEMCTL 4'h6
`define IBDA_SEL_SERIAL 4'h7
`define IBDA_SEL_CACHE 4'h8
`endif

/* src/ibda_bus.v */
// internal system bus: round-robin arbiter, address decoder and privilege gate
//
// What this block does
// - every internal module sits at the top of the map with a 1 MB window
// - addresses 0000_0000 to FF7F_FFFF go to the external bus module
// - FF8 frontend, FF9 DMA, FFA host interface windows, one megabyte each
// - FFB system services, FFC memory controller, FFD serial windows, one megabyte each
// - FFF window selects cache RAM only when the cache variant is built
// - processor register access refused unless supervisor mode flag is set
// - override bit lets the processor reach registers in user mode
// - external master refused register access unless its permission bit is set
// - external master register decode ignores the top four address bits
// - outside a locked burst or rmw, no master gets back-to-back cycles while another master waits
// - a started burst keeps the bus until the burst ends
// - read-modify-write keeps the bus for all its consecutive cycles
// - grants rotate round-robin, idle masters skipped
// - four masters: processor, DMA, host interface, external bus master
`timescale 1ns/1ns
`include "ibda_defines.vh"
module ibda_bus #(
   parameter NM = 4,
   parameter HAS_CACHE = 1
) (
   input wire clk_sys_in,
   input wire nrst_in,
   input wire [NM-1:0] req_in,
   input wire [NM-1:0] lock_in,
   input wire [32*NM-1:0] addr_in,
   input wire [NM-1:0] write_in,
   input wire supervisor_mode_flag_in,
   input wire unprivileged_access_override_in,
   input wire external_master_register_access_in,
   input wire slave_done_in,
   output wire [NM-1:0] grant_out,
   output reg [3:0] select_out,
   output reg [31:0] addr_out,
   output reg write_out,
   output reg strobe_out,
   output wire done_out,
   output reg error_out
);
localparam ST_IDLE = 2'h0;
localparam ST_SLAVE = 2'h1;
localparam ST_ERROR = 2'h2;
reg [1:0] state;
reg [1:0] owner;
reg [1:0] last;
reg held;
reg [1:0] next_owner;
reg next_found;
reg [3:0] next_sel;
reg next_refuse;
reg [31:0] cur_addr;
reg [31:0] cmp_addr;
reg is_reg;
integer k;
integer idx;
////////////////////////////////////////////////////////////////////////
// round-robin pick starting after the last owner
always @* begin
   next_owner = last;
   next_found = 1'b0;
   idx = 0;
   for (k = NM; k >= 1; k = k - 1) begin
      idx = (last + k) % NM;
      if (req_in[idx]) begin
         next_owner = idx[1:0];
         next_found = 1'b1;
      end
   end
   // a held owner continues through a burst or rmw sequence; the final
   // cycle of the burst has its lock low already, so lock is not looked at here
   if (held && req_in[last]) begin
      next_owner = last;
      next_found = 1'b1;
   end
end
////////////////////////////////////////////////////////////////////////
// decode of the chosen master's address
always @* begin
   cur_addr = addr_in[32*next_owner +: 32];
   cmp_addr = cur_addr;
   if (next_owner == `IBDA_M_EXTBUS) begin
      // top nibble has no pins on the external bus
      cmp_addr = {`IBDA_EXT_TOP4, cur_addr[27:0]};
   end
   next_sel = `IBDA_SEL_NONE;
   is_reg = 1'b1;
   if (cmp_addr <= `IBDA_EXT_LAST) begin
      next_sel = `IBDA_SEL_EXTBUS;
      is_reg = 1'b0;
   end else begin
      case (cmp_addr[31:20])
         `IBDA_WIN_FRONTEND: next_sel = `IBDA_SEL_FRONTEND;
         `IBDA_WIN_DMA: next_sel = `IBDA_SEL_DMA;
         `IBDA_WIN_HOSTIF: next_sel = `IBDA_SEL_HOSTIF;
         `IBDA_WIN_SYSSVC: next_sel = `IBDA_SEL_SYSSVC;
         `IBDA_WIN_MEMCTL: next_sel = `IBDA_SEL_MEMCTL;
         `IBDA_WIN_SERIAL: next_sel = `IBDA_SEL_SERIAL;
         `IBDA_WIN_CACHE: next_sel = (HAS_CACHE != 0) ? `IBDA_SEL_CACHE : `IBDA_SEL_NONE;
         default: next_sel = `IBDA_SEL_NONE;
      endcase
   end
   next_refuse = 1'b0;
   if (is_reg && next_owner == `IBDA_M_CPU && !supervisor_mode_flag_in && !unprivileged_access_override_in) begin
      next_refuse = 1'b1;
   end
   if (is_reg && next_owner == `IBDA_M_EXTBUS && !external_master_register_access_in) begin
      next_refuse = 1'b1;
   end
end
////////////////////////////////////////////////////////////////////////
// one transaction at a time; grant stands until done
wire take;
wire take_err;
wire slave_end;
assign take = (state == ST_IDLE) && next_found;
assign take_err = (next_sel == `IBDA_SEL_NONE) || next_refuse;
assign slave_end = (state == ST_SLAVE) && slave_done_in;
assign done_out = (state == ST_ERROR) || slave_end;

genvar gi;
generate
   for (gi = 0; gi < NM; gi = gi + 1) begin : g_grant
      localparam [1:0] MID = gi;
      // decoded from the single owner register, so never two-hot
      assign grant_out[gi] = (state != ST_IDLE) && (owner == MID);
   end
endgenerate

////////////////////////////////////////////////////////////////////////
// sequencer: idle, slave cycle or error answer
always @(posedge clk_sys_in) begin
   if (!nrst_in) begin
      state <= ST_IDLE;
   end else begin
      case (state)
         ST_IDLE: begin
            if (take) begin
               if (take_err) begin
                  state <= ST_ERROR;
               end else begin
                  state <= ST_SLAVE;
               end
            end
         end
         ST_SLAVE: begin
            if (slave_done_in) begin
               state <= ST_IDLE;
            end
         end
         ST_ERROR: begin
            state <= ST_IDLE;
         end
         default: begin
            state <= ST_IDLE;
         end
      endcase
   end
end

////////////////////////////////////////////////////////////////////////
// owner and rotation pointer
// pointer starts on the external master so the processor is served first
always @(posedge clk_sys_in) begin
   if (!nrst_in) begin
      owner <= 2'h0;
      last <= 2'h3;
   end else if (take) begin
      owner <= next_owner;
      last <= next_owner;
   end
end

// raw address is passed on; the masked form only steers the decode
always @(posedge clk_sys_in) begin
   if (!nrst_in) begin
      addr_out <= 32'h00000000;
      write_out <= 1'b0;
   end else if (take) begin
      addr_out <= cur_addr;
      write_out <= write_in[next_owner];
   end
end

////////////////////////////////////////////////////////////////////////
// target strobe and select
// a refused or unmapped access never strobes, so no target register moves
always @(posedge clk_sys_in) begin
   if (!nrst_in) begin
      select_out <= `IBDA_SEL_NONE;
      strobe_out <= 1'b0;
   end else if (take && !take_err) begin
      select_out <= next_sel;
      strobe_out <= 1'b1;
   end else if (slave_end) begin
      select_out <= `IBDA_SEL_NONE;
      strobe_out <= 1'b0;
   end
end

// error answer stands one cycle after the done pulse
always @(posedge clk_sys_in) begin
   if (!nrst_in) begin
      error_out <= 1'b0;
   end else begin
      error_out <= (state == ST_ERROR);
   end
end

////////////////////////////////////////////////////////////////////////
// bus hold for burst and rmw
// lock seen at the end of a cycle decides whether the owner keeps the bus
always @(posedge clk_sys_in) begin
   if (!nrst_in) begin
      held <= 1'b0;
   end else if (slave_end) begin
      held <= lock_in[owner];
   end else if (state == ST_ERROR) begin
      // an error ends the burst and the bus goes on round
      held <= 1'b0;
   end
end

endmodule

/* tb/ibda_bus_monitor.sv */
// concurrent checks on the bus decoder and arbiter ports
`timescale 1ns/1ns
module ibda_monitor (
   input wire clk_sys_in,
   input wire nrst_in,
   input wire [3:0] req_in,
   input wire [3:0] lock_in,
   input wire supervisor_mode_flag_in,
   input wire unprivileged_access_override_in,
   input wire external_master_register_access_in,
   input wire [3:0] grant_out,
   input wire [3:0] select_out,
   input wire [31:0] addr_out,
   input wire strobe_out,
   input wire done_out,
   input wire error_out
);
   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (!nrst_in);
   // ext master has no top four pins, so only bits 27..0 mean anything
   wire ext_reg = strobe_out && grant_out[3] && addr_out[27:23] == 5'h1F;
   wire cpu_reg = strobe_out && grant_out[0] && addr_out[31:23] == 9'h1FF;
   wire held = (grant_out & lock_in) != 4'h0;
   a_one_owner: assert property ($onehot0(grant_out)) else $error("two owners");
   a_refuse_err: assert property (done_out && !strobe_out |=> error_out) else $error("no error");
   a_ext_route: assert property (strobe_out && !grant_out[3] && addr_out <= 32'hFF7FFFFF |->
      select_out == 4'h1) else $error("ext route");
   a_dma_win: assert property (strobe_out && !grant_out[3] && addr_out[31:20] == 12'hFF9 |->
      select_out == 4'h3) else $error("dma window");
   a_cpu_priv: assert property (cpu_reg |-> supervisor_mode_flag_in ||
      unprivileged_access_override_in) else $error("user access");
   a_ext_perm: assert property (ext_reg |-> external_master_register_access_in) else $error("ext perm");
   a_ext_mask: assert property (ext_reg && addr_out[27:20] == 8'hFB |-> select_out == 4'h5)
      else $error("ext mask");
   a_lock_hold: assert property (done_out && held |=> ##1 grant_out == $past(grant_out, 2))
      else $error("lock lost");
   a_no_repeat: assert property (done_out && !held && (req_in & ~grant_out) != 4'h0 |=> ##1
      grant_out != $past(grant_out, 2)) else $error("repeat grant");
   cover property (error_out);
   cover property (done_out && held);
   cover property (ext_reg);
endmodule
bind ibda_bus ibda_monitor mon_u (.*);

/* tb/ibda_slave_model.sv */
// slave answering each strobe after a chosen number of wait cycles
`timescale 1ns/1ns
module ibda_slave_model (
   input wire clk_sys_in,
   input wire strobe_in,
   input wire [3:0] wait_in,
   output wire done_out
);
   reg [3:0] count;
   always @(posedge clk_sys_in) begin
      count <= (strobe_in && !done_out) ? count + 4'h1 : 4'h0;
   end
   assign done_out = strobe_in && count == wait_in;
endmodule

/* tb/ibda_bus_tb.sv */
// self-checking bench for the bus decoder and arbiter
`timescale 1ns/1ns
module ibda_bus_tb;
   reg clk_sys_in = 1'b0;
   reg nrst_in = 1'b0;
   reg [3:0] req_in = 4'h0;
   reg [3:0] lock_in = 4'h0;
   reg [127:0] addr_in = 128'h0;
   reg [3:0] write_in = 4'h0;
   reg sup = 1'b0, ovr = 1'b0, xacc = 1'b0;
   reg [3:0] wait_cyc = 4'h0;
   wire [3:0] grant_out, select_out;
   wire [31:0] addr_out;
   wire write_out, strobe_out, done_out, error_out, sdone;
   integer fail_count = 0, compares = 0;
   ibda_bus dut_u (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .req_in(req_in), .lock_in(lock_in),
      .addr_in(addr_in), .write_in(write_in), .supervisor_mode_flag_in(sup),
      .unprivileged_access_override_in(ovr), .external_master_register_access_in(xacc),
      .slave_done_in(sdone), .grant_out(grant_out), .select_out(select_out), .addr_out(addr_out),
      .write_out(write_out), .strobe_out(strobe_out), .done_out(done_out), .error_out(error_out));
   ibda_slave_model slave_u (.clk_sys_in(clk_sys_in), .strobe_in(strobe_out), .wait_in(wait_cyc), .done_out(sdone));
   initial begin
      forever #2 clk_sys_in = ~clk_sys_in;
   end
   ////////////////////////////////////////////////////////////////
   task chk(input [31:0] got, input [31:0] exp);
      begin
         compares = compares + 1;
         if (got !== exp) begin
            fail_count = fail_count + 1;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
         end
      end
   endtask
   // waits out one transaction; returns a cycle after done, in the idle gap
   task wt(output [3:0] g, output [3:0] s, output e);
      integer n;
      begin
         n = 0;
         while (done_out !== 1'b1 && n < 60) begin
            @(posedge clk_sys_in);
            #1 n = n + 1;
         end
         g = grant_out;
         s = select_out;
         @(posedge clk_sys_in);
         #1 e = error_out;
      end
   endtask
   task xfer(input [1:0] m, input [31:0] a, input [3:0] es, input ee);
      reg [3:0] g, s;
      reg e;
      begin
         @(posedge clk_sys_in);
         #1 addr_in[32*m+:32] = a;
         write_in[m] = a[4];
         req_in[m] = 1'b1;
         wt(g, s, e);
         req_in[m] = 1'b0;
         write_in[m] = 1'b0;
         chk(g, 4'h1 << m);
         chk(s, es);
         chk(e, ee);
         chk(addr_out, a);
         chk(write_out, a[4]);
      end
   endtask
   ////////////////////////////////////////////////////////////////
   task t_map;
      integer i;
      begin
         sup = 1'b1;
         xfer(0, 32'h0, 4'h1, 1'b0);
         xfer(0, 32'hFF7FFFFF, 4'h1, 1'b0);
         for (i = 0; i < 6; i = i + 1) xfer(0, 32'hFF8FFFFC + (i << 20), i + 2, 1'b0);
         xfer(0, 32'hFFF00000, 4'h8, 1'b0);
         xfer(1, 32'hFFE00010, 4'h0, 1'b1);
      end
   endtask
   task t_priv;
      begin
         sup = 1'b0;
         xfer(0, 32'hFFC00000, 4'h0, 1'b1);
         xfer(0, 32'h00000040, 4'h1, 1'b0);
         ovr = 1'b1;
         xfer(0, 32'hFFC00000, 4'h6, 1'b0);
         ovr = 1'b0;
         xfer(3, 32'h0FB00000, 4'h0, 1'b1);
         xacc = 1'b1;
         xfer(3, 32'h0FB00000, 4'h5, 1'b0);
      end
   endtask
   task t_arb;
      reg [3:0] g1, g2, g3, s;
      reg e;
      begin
         sup = 1'b1;
         wait_cyc = 4'h3;
         addr_in = 128'h0;
         req_in = 4'h3;
         wt(g1, s, e);
         wt(g2, s, e);
         wt(g3, s, e);
         chk(g1 ^ g2, 4'h3);
         chk(g3, g1);
         lock_in = 4'h3;
         wt(g1, s, e);
         lock_in = 4'h0;
         wt(g2, s, e);
         wt(g3, s, e);
         req_in = 4'h0;
         chk(g2, g1);
         chk(g3 ^ g1, 4'h3);
      end
   endtask
   task end_of_test;
      begin
         if (fail_count == 0 && compares > 0) $display("SIMULATION PASSED");
         else $display("SIMULATION FAILED");
         $finish;
      end
   endtask
   initial begin
      repeat (20) @(posedge clk_sys_in);
      #1 nrst_in = 1'b1;
      t_map;
      t_priv;
      t_arb;
      end_of_test;
   end
   initial begin
      #20000 fail_count = fail_count + 1;
      end_of_test;
   end
endmodule
